// ===== core/mkxm_mapper.sv
// Key stream segment to tail and B-field XOR mapper with AXI4-Lite control
`timescale 1ns/100ps
module mkxm_mapper (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // AXI4-Lite write
   input  wire logic [31:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [31:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Key stream in
   input  wire logic        ksValid,
   input  wire logic        ksBit,
   output logic             ksReady,
   // Field bits in
   input  wire logic        fldValid,
   input  wire logic        fldBit,
   output logic             fldReady,
   // Field bits out
   output logic             outValid,
   output logic             outBit,
   input  wire logic        outReady
);
   typedef enum logic {ST_IDLE, ST_RUN} mkxm_state_t;

   mkxm_state_t         state_q;
   mkxm_pkg::mkxm_ctrl_t ctrl_q;
   logic [12:0]         limit_q;
   logic [12:0]         idx_q;
   logic [6:0]          subIdx_q;
   logic                seg_q;
   logic                startReq_q;
   logic                gotKey_q, gotFld_q, keyBit_q, fldBit_q;
   logic                awGot_q, wGot_q;
   logic [7:0]          awAddr_q;
   logic [31:0]         wData_q;
   logic [3:0]          wStrb_q;
   logic [12:0]         tailLen, keyB, bLen, segLen, stepEnd, bIdx;
   logic                inTail, needKey, needFld, xorEn, stepDone, lastStep;
   logic [31:0]         wMerged;

   // ----------------------------------------
   // Geometry decode
   // ----------------------------------------
   function automatic logic [12:0] tailOf(input mkxm_pkg::mkxm_cfg_t c);
      unique case (c)
         mkxm_pkg::CFG_4A: tailOf = 13'(mkxm_pkg::TAIL_BASE * 2);
         mkxm_pkg::CFG_4B: tailOf = 13'(mkxm_pkg::TAIL_BASE * 3);
         default:          tailOf = mkxm_pkg::TAIL_BASE;
      endcase
   endfunction : tailOf

   function automatic logic [12:0] keyBOf(input mkxm_pkg::mkxm_cfg_t c, input mkxm_pkg::mkxm_slot_t s);
      logic [12:0] u;
      logic [2:0]  m;
      unique case (s)
         mkxm_pkg::SLOT_DOUBLE:  u = mkxm_pkg::UNIT_DOUBLE;
         mkxm_pkg::SLOT_FULL:    u = mkxm_pkg::UNIT_FULL;
         mkxm_pkg::SLOT_HALF:    u = mkxm_pkg::UNIT_HALF;
         mkxm_pkg::SLOT_LONG640: u = mkxm_pkg::UNIT_LONG640;
         mkxm_pkg::SLOT_LONG672: u = mkxm_pkg::UNIT_LONG672;
         default:                u = 13'h0000;
      endcase
      unique case (c)
         mkxm_pkg::CFG_1A, mkxm_pkg::CFG_1B: m = 3'h1;
         mkxm_pkg::CFG_2, mkxm_pkg::CFG_4A:  m = 3'h2;
         mkxm_pkg::CFG_3, mkxm_pkg::CFG_4B:  m = 3'h3;
         mkxm_pkg::CFG_5:                    m = 3'h4;
         mkxm_pkg::CFG_6:                    m = 3'h6;
      endcase
      keyBOf = 13'(u * m);
   endfunction : keyBOf

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
      end
   endfunction : merge

   always_comb begin
      tailLen = tailOf(ctrl_q.cfg);
      keyB    = keyBOf(ctrl_q.cfg, ctrl_q.slot);
      bLen    = keyB;
      if (ctrl_q.slot == mkxm_pkg::SLOT_HALF && ctrl_q.cfg == mkxm_pkg::CFG_6) begin
         bLen = mkxm_pkg::HALF_C6_BLEN;
      end
      segLen   = 13'(tailLen + keyB);
      stepEnd  = 13'(tailLen + bLen);
      bIdx     = 13'(idx_q - tailLen);
      inTail   = idx_q < tailLen;
      needKey  = idx_q < segLen;
      needFld  = inTail ? ctrl_q.ctrlTail : (bIdx < bLen);
      lastStep = idx_q == 13'(stepEnd - 13'h0001);
   end

   // ----------------------------------------
   // XOR enable per position
   // ----------------------------------------
   always_comb begin
      xorEn = 1'b0;
      if (inTail) begin
         xorEn = ctrl_q.ctrlTail;
      end else if (needKey) begin
         unique case (ctrl_q.fmt)
            mkxm_pkg::FMT_UNPROT:  xorEn = 1'b1;
            mkxm_pkg::FMT_MULTI:   xorEn = subIdx_q < mkxm_pkg::SUB_DATA;
            mkxm_pkg::FMT_SINGLE:  xorEn = bIdx < limit_q;
            mkxm_pkg::FMT_ENCODED: xorEn = bIdx < limit_q;
         endcase
      end
   end

   assign stepDone = state_q == ST_RUN && (gotKey_q || !needKey) && (gotFld_q || !needFld) && !outValid;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q  <= ST_IDLE;
         idx_q    <= 13'h0000;
         subIdx_q <= 7'h00;
         seg_q    <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (startReq_q) begin
                  state_q  <= ST_RUN;
                  idx_q    <= 13'h0000;
                  subIdx_q <= 7'h00;
                  seg_q    <= 1'b0;
               end
            end
            ST_RUN: begin
               if (stepDone) begin
                  if (lastStep) begin
                     idx_q    <= 13'h0000;
                     subIdx_q <= 7'h00;
                     seg_q    <= ~seg_q;
                     if (seg_q) begin
                        state_q <= ST_IDLE;
                     end
                  end else begin
                     idx_q <= 13'(idx_q + 13'h0001);
                     if (!inTail) begin
                        subIdx_q <= (subIdx_q == 7'(mkxm_pkg::SUB_SPAN - 7'h01)) ? 7'h00 : 7'(subIdx_q + 7'h01);
                     end
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Key and field intake
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gotKey_q <= 1'b0;
         keyBit_q <= 1'b0;
         ksReady  <= 1'b0;
      end else if (ksValid && ksReady) begin
         gotKey_q <= 1'b1;
         keyBit_q <= ksBit;
         ksReady  <= 1'b0;
      end else if (stepDone) begin
         gotKey_q <= 1'b0;
      end else begin
         ksReady <= state_q == ST_RUN && needKey && !gotKey_q;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gotFld_q <= 1'b0;
         fldBit_q <= 1'b0;
         fldReady <= 1'b0;
      end else if (fldValid && fldReady) begin
         gotFld_q <= 1'b1;
         fldBit_q <= fldBit;
         fldReady <= 1'b0;
      end else if (stepDone) begin
         gotFld_q <= 1'b0;
      end else begin
         fldReady <= state_q == ST_RUN && needFld && !gotFld_q;
      end
   end

   // ----------------------------------------
   // Output stage
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         outValid <= 1'b0;
         outBit   <= 1'b0;
      end else if (stepDone && needFld) begin
         outValid <= 1'b1;
         outBit   <= fldBit_q ^ (xorEn & keyBit_q);
      end else if (outReady) begin
         outValid <= 1'b0;
      end
   end

   // ----------------------------------------
   // AXI4-Lite write
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         awGot_q  <= 1'b0;
         wGot_q   <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q  <= 32'h00000000;
         wStrb_q  <= 4'h0;
         awready  <= 1'b0;
         wready   <= 1'b0;
         bvalid   <= 1'b0;
         bresp    <= mkxm_pkg::RESP_OKAY;
      end else begin
         awready <= !awGot_q && !bvalid && !(awvalid && awready);
         wready  <= !wGot_q && !bvalid && !(wvalid && wready);
         if (awvalid && awready) begin
            awGot_q  <= 1'b1;
            awAddr_q <= (awaddr[31:8] == 24'h000000) ? awaddr[7:0] : 8'hff;
         end
         if (wvalid && wready) begin
            wGot_q  <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end
         if (awGot_q && wGot_q && !bvalid) begin
            awGot_q <= 1'b0;
            wGot_q  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= (awAddr_q == mkxm_pkg::ADDR_CTRL || awAddr_q == mkxm_pkg::ADDR_LIMIT ||
                        awAddr_q == mkxm_pkg::ADDR_STATUS) ? mkxm_pkg::RESP_OKAY : mkxm_pkg::RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      if (awAddr_q == mkxm_pkg::ADDR_CTRL) begin
         wMerged = merge({23'h000000, ctrl_q}, wData_q, wStrb_q);
      end else begin
         wMerged = merge({19'h00000, limit_q}, wData_q, wStrb_q);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q     <= mkxm_pkg::mkxm_ctrl_t'(mkxm_pkg::CTRL_RST);
         limit_q    <= mkxm_pkg::LIMIT_RST;
         startReq_q <= 1'b0;
      end else begin
         startReq_q <= 1'b0;
         if (awGot_q && wGot_q && !bvalid && state_q == ST_IDLE && !startReq_q) begin
            if (awAddr_q == mkxm_pkg::ADDR_CTRL) begin
               ctrl_q     <= mkxm_pkg::mkxm_ctrl_t'(wMerged[mkxm_pkg::CTRLT_BIT:mkxm_pkg::CFG_LSB]);
               startReq_q <= wStrb_q[1] && wData_q[mkxm_pkg::START_BIT];
            end else if (awAddr_q == mkxm_pkg::ADDR_LIMIT) begin
               limit_q <= wMerged[12:0];
            end
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite read
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= mkxm_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= mkxm_pkg::RESP_OKAY;
         rdata   <= 32'h00000000;
         if (araddr == 32'(mkxm_pkg::ADDR_CTRL)) begin
            rdata <= {23'h000000, ctrl_q};
         end else if (araddr == 32'(mkxm_pkg::ADDR_LIMIT)) begin
            rdata <= {19'h00000, limit_q};
         end else if (araddr == 32'(mkxm_pkg::ADDR_STATUS)) begin
            rdata <= {17'h00000, idx_q, seg_q, state_q == ST_RUN || startReq_q};
         end else begin
            rresp <= mkxm_pkg::RESP_SLVERR;
         end
      end else if (rvalid) begin
         rvalid <= !rready;
      end else begin
         arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_tailXor;
      @(posedge clk) disable iff (!rstn)
      stepDone && inTail && ctrl_q.ctrlTail |=> outValid && outBit == ($past(fldBit_q) ^ $past(keyBit_q));
   endproperty
   a_tailXor: assert property (p_tailXor) else $error("tail bit not xored");

   property p_unprotXor;
      @(posedge clk) disable iff (!rstn)
      stepDone && !inTail && needKey && needFld && ctrl_q.fmt == mkxm_pkg::FMT_UNPROT
      |=> outBit == ($past(fldBit_q) ^ $past(keyBit_q));
   endproperty
   a_unprotXor: assert property (p_unprotXor) else $error("B bit not xored");

   property p_checkClear;
      @(posedge clk) disable iff (!rstn)
      stepDone && !inTail && needFld && ctrl_q.fmt == mkxm_pkg::FMT_MULTI && subIdx_q >= mkxm_pkg::SUB_DATA
      |=> outBit == $past(fldBit_q);
   endproperty
   a_checkClear: assert property (p_checkClear) else $error("check bit ciphered");

   property p_encLimit;
      @(posedge clk) disable iff (!rstn)
      stepDone && !inTail && needFld && ctrl_q.fmt == mkxm_pkg::FMT_ENCODED && bIdx >= limit_q
      |=> outBit == $past(fldBit_q);
   endproperty
   a_encLimit: assert property (p_encLimit) else $error("encoded bit past limit ciphered");

   property p_dropNoOut;
      @(posedge clk) disable iff (!rstn)
      stepDone && !needFld |=> !outValid;
   endproperty
   a_dropNoOut: assert property (p_dropNoOut) else $error("dropped key bit produced output");

   property p_startZero;
      @(posedge clk) disable iff (!rstn)
      state_q == ST_IDLE && startReq_q |=> state_q == ST_RUN && idx_q == 13'h0000 && !seg_q;
   endproperty
   a_startZero: assert property (p_startZero) else $error("segment not started at zero");

   property p_secondSeg;
      @(posedge clk) disable iff (!rstn)
      stepDone && lastStep && !seg_q |=> seg_q && idx_q == 13'h0000 && state_q == ST_RUN;
   endproperty
   a_secondSeg: assert property (p_secondSeg) else $error("second segment missing");

   property p_tail4b;
      @(posedge clk) disable iff (!rstn)
      state_q == ST_RUN && ctrl_q.cfg == mkxm_pkg::CFG_4B |-> tailLen == 13'd120 && segLen == 13'(13'd120 + keyB);
   endproperty
   a_tail4b: assert property (p_tail4b) else $error("4b tail length wrong");

   property p_keyTaken;
      @(posedge clk) disable iff (!rstn)
      stepDone && needKey |-> gotKey_q;
   endproperty
   a_keyTaken: assert property (p_keyTaken) else $error("key bit skipped");

   c_twoSeg:  cover property (@(posedge clk) disable iff (!rstn) stepDone && lastStep && seg_q);
   c_multi:   cover property (@(posedge clk) disable iff (!rstn) stepDone && ctrl_q.fmt == mkxm_pkg::FMT_MULTI);
   c_noCtrlT: cover property (@(posedge clk) disable iff (!rstn) stepDone && inTail && !ctrl_q.ctrlTail);
endmodule : mkxm_mapper

// ===== core/mkxm_pkg.sv
// Constants and types of the multilevel key stream XOR mapper
package mkxm_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_LIMIT  = 8'h04;
   localparam logic [7:0]  ADDR_STATUS = 8'h08;
   localparam int          CFG_LSB     = 0;
   localparam int          SLOT_LSB    = 3;
   localparam int          FMT_LSB     = 6;
   localparam int          CTRLT_BIT   = 8;
   localparam int          START_BIT   = 9;
   localparam logic [8:0]  CTRL_RST    = 9'h000;
   localparam logic [12:0] LIMIT_RST   = 13'h0000;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // Segment geometry
   // ----------------------------------------
   localparam logic [12:0] TAIL_BASE    = 13'h0028;
   localparam logic [12:0] UNIT_DOUBLE  = 13'h0320;
   localparam logic [12:0] UNIT_FULL    = 13'h0140;
   localparam logic [12:0] UNIT_HALF    = 13'h0050;
   localparam logic [12:0] UNIT_LONG640 = 13'h0280;
   localparam logic [12:0] UNIT_LONG672 = 13'h02a0;
   localparam logic [12:0] HALF_C6_BLEN = 13'h0230;
   localparam logic [6:0]  SUB_SPAN     = 7'h50;
   localparam logic [6:0]  SUB_DATA     = 7'h40;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {CFG_1A, CFG_1B, CFG_2, CFG_3, CFG_4A, CFG_4B, CFG_5, CFG_6} mkxm_cfg_t;
   typedef enum logic [2:0] {SLOT_DOUBLE, SLOT_FULL, SLOT_HALF, SLOT_LONG640, SLOT_LONG672,
                             SLOT_RSV5, SLOT_RSV6, SLOT_RSV7} mkxm_slot_t;
   typedef enum logic [1:0] {FMT_UNPROT, FMT_SINGLE, FMT_MULTI, FMT_ENCODED} mkxm_fmt_t;
   typedef struct packed {
      logic       ctrlTail;
      mkxm_fmt_t  fmt;
      mkxm_slot_t slot;
      mkxm_cfg_t  cfg;
   } mkxm_ctrl_t;
endpackage : mkxm_pkg

// ===== bench/mkxm_ks_source.sv
// Key stream generator model feeding the mapper
`timescale 1ns/100ps
module mkxm_ks_source (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Pacing
   input  wire logic slow,
   // Key stream
   input  wire logic ksReady,
   output logic      ksValid,
   output logic      ksBit,
   output int        taken
);
   int gap;
   function automatic logic kbit(input int n);
      return n[0] ^ n[2] ^ n[5] ^ n[7];
   endfunction : kbit
   // ----------------------------------------
   // Bit source, prompt or with gaps
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ksValid <= 1'b0;
         ksBit   <= 1'b0;
         taken   <= 0;
         gap     <= 0;
      end else if (ksValid && ksReady) begin
         taken   <= taken + 1;
         ksValid <= !slow;
         ksBit   <= slow ? ~ksBit : kbit(taken + 1);
         gap     <= slow ? 3 : 0;
      end else if (!ksValid && gap != 0) begin
         gap     <= gap - 1;
         ksBit   <= ~ksBit;
      end else if (!ksValid) begin
         ksValid <= 1'b1;
         ksBit   <= kbit(taken);
      end
   end
endmodule : mkxm_ks_source

// ===== bench/multilevel_keystream_xor_map_tb.sv
// Self-checking bench of the key stream XOR mapper
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checkCount++; if ((e) !== (g)) begin failCount++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module multilevel_keystream_xor_map_tb;
   logic        clk, rstn, ksSlow;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic        ksValid, ksBit, ksReady, fldValid, fldBit, fldReady;
   logic        outValid, outBit, outReady;
   int          taken, failCount, checkCount;
   int          gTl, gKb, gBl, gFmt, gLim, gCtl, gK0;
   int          grp [8] = '{1, 1, 2, 3, 2, 3, 4, 6};
   int          unit [5] = '{800, 320, 80, 640, 672};
   // ----------------------------------------
   // Design and key source
   // ----------------------------------------
   mkxm_mapper i_dut (.clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .ksValid(ksValid), .ksBit(ksBit),
      .ksReady(ksReady), .fldValid(fldValid), .fldBit(fldBit), .fldReady(fldReady),
      .outValid(outValid), .outBit(outBit), .outReady(outReady));
   mkxm_ks_source i_ks (.clk(clk), .rstn(rstn), .slow(ksSlow), .ksReady(ksReady), .ksValid(ksValid),
      .ksBit(ksBit), .taken(taken));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic kbit(input int n);
      return n[0] ^ n[2] ^ n[5] ^ n[7];
   endfunction : kbit
   function automatic logic fpat(input int n);
      return n[1] ^ n[4] ^ n[6];
   endfunction : fpat
   function automatic logic expo(input int j);
      int per, s, p, i, base;
      logic cip;
      per = (gCtl ? gTl : 0) + gBl;
      s = j / per;
      p = j % per;
      base = gK0 + s * (gTl + gKb);
      if (gCtl && p < gTl) return fpat(j) ^ kbit(base + p);
      i = p - (gCtl ? gTl : 0);
      cip = i < gKb;
      if (gFmt == 2) cip = cip && (i % 80 < 64);
      if (gFmt == 1 || gFmt == 3) cip = cip && (i < gLim);
      return cip ? fpat(j) ^ kbit(base + gTl + i) : fpat(j);
   endfunction : expo
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aDone, wDone;
      aDone = 1'b0;
      wDone = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aDone && wDone)) begin
         @(posedge clk);
         if (!aDone && awready) begin
            aDone = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wDone && wready) begin
            wDone = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read
   task automatic feed(input int n);
      for (int j = 0; j < n; j++) begin
         fldValid <= 1'b1;
         fldBit <= fpat(j);
         do @(posedge clk); while (!fldReady);
      end
      fldValid <= 1'b0;
      fldBit <= ~fpat(n - 1);
   endtask : feed
   task automatic drain(input int n);
      int j, c;
      j = 0;
      c = 0;
      while (j < n) begin
         @(posedge clk);
         if (outValid && outReady) begin
            `CHK("outBit", expo(j), outBit)
            j++;
         end
         c++;
         outReady <= (c % 4 != 3);
      end
   endtask : drain
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      axi_read({24'h0, mkxm_pkg::ADDR_CTRL}, d, r);
      `CHK("ctrl reset", 32'h0, d)
      axi_read({24'h0, mkxm_pkg::ADDR_LIMIT}, d, r);
      `CHK("limit reset", 32'h0, d)
      axi_write(32'h0000_000c, 32'h0000_0001, r);
      `CHK("unmapped wr resp", mkxm_pkg::RESP_SLVERR, r)
      axi_read(32'h0000_000c, d, r);
      `CHK("unmapped rd resp", mkxm_pkg::RESP_SLVERR, r)
      axi_write({24'h0, mkxm_pkg::ADDR_LIMIT}, 32'h0000_1abc, r);
      axi_read({24'h0, mkxm_pkg::ADDR_LIMIT}, d, r);
      `CHK("limit rw", 32'h0000_1abc, d & 32'h0000_1fff)
      $display("Test regs done");
   endtask : t_regs
   task automatic run(input int cfg, input int slot, input int fmt, input int ctl, input int lim);
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      gTl = (cfg == 4) ? 80 : (cfg == 5) ? 120 : 40;
      gKb = unit[slot] * grp[cfg];
      gBl = (slot == 2 && cfg == 7) ? 560 : gKb;
      gFmt = fmt;
      gLim = lim;
      gCtl = ctl;
      gK0 = taken;
      n = 2 * ((ctl ? gTl : 0) + gBl);
      axi_write({24'h0, mkxm_pkg::ADDR_LIMIT}, 32'(lim), r);
      d = 32'(cfg) | (32'(slot) << mkxm_pkg::SLOT_LSB) | (32'(fmt) << mkxm_pkg::FMT_LSB);
      d = d | (32'(ctl) << mkxm_pkg::CTRLT_BIT) | (32'h1 << mkxm_pkg::START_BIT);
      axi_write({24'h0, mkxm_pkg::ADDR_CTRL}, d, r);
      fork
         feed(n);
         drain(n);
      join
      for (int k = 0; k < 40; k++) begin
         axi_read({24'h0, mkxm_pkg::ADDR_STATUS}, d, r);
         if (d[0] === 1'b0) break;
      end
      `CHK("busy", 1'b0, d[0])
      `CHK("key bits taken", 2 * (gTl + gKb), taken - gK0)
      $display("Test run cfg %0d slot %0d fmt %0d done", cfg, slot, fmt);
   endtask : run
   // ----------------------------------------
   // Clock, reset, sequence, watchdog
   // ----------------------------------------
   task automatic close_out;
      $display("Checks %0d mismatches %0d", checkCount, failCount);
      if (failCount == 0 && checkCount > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {rstn, ksSlow, awvalid, wvalid, bready, arvalid, rready, fldValid, fldBit, outReady} = '0;
      {awaddr, wdata, araddr} = '0;
      wstrb = 4'hf;
      failCount = 0;
      checkCount = 0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_regs();
      for (int c = 0; c < 8; c++) begin
         ksSlow <= c[0];
         run(c, 2, 0, c % 2 == 0, 0);
      end
      ksSlow <= 1'b0;
      run(0, 0, 0, 1, 0);
      run(0, 1, 1, 1, 304);
      run(0, 3, 0, 0, 0);
      run(1, 4, 0, 1, 0);
      run(0, 2, 2, 1, 0);
      run(4, 2, 3, 0, 80);
      close_out();
   end
   initial begin
      repeat (100000) @(posedge clk);
      failCount++;
      close_out();
   end
endmodule : multilevel_keystream_xor_map_tb
